// file: logic/bpc_consts.svh
// constants of the block protection command controller
// Contract
// - byte-mode entry: AAA/AA, 555/55, AAA/code
// - word-mode entry: 555/AA, 2AA/55, 555/code
// - exit is 90 then 00, don't-care address
// - enter before set operations; exit afterwards
// - register and password reads are plain reads
// - lock register program: A0 then data
// - password portion program: A0, data at address
// - word-mode password read: addresses 00 to 03
// - byte-mode password read: addresses 00 to 07
// - unlock: 25@00, 03@00, portions, 29@00
// - unlock is 11 cycles byte, 7 word
// - nonvolatile set: A0 then 00 protects block
// - clear all: 80 anywhere, then 30 at 00
// - unlock commands at least 6 us apart
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH
`define BPC_AW 24
`define BPC_A_AAA 24'haaa
`define BPC_A_555 24'h555
`define BPC_A_2AA 24'h2aa
`define BPC_A_ZERO 24'h000
`define BPC_D_UNL1 8'haa
`define BPC_D_UNL2 8'h55
`define BPC_SET_LOCKREG 8'h40
`define BPC_SET_PWD 8'h60
`define BPC_SET_NVB 8'hc0
`define BPC_SET_LOCKBIT 8'h50
`define BPC_SET_VOLB 8'he0
`define BPC_SET_EXTMEM 8'h88
`define BPC_D_EXIT1 8'h90
`define BPC_D_EXIT2 8'h00
`define BPC_D_PROG 8'ha0
`define BPC_D_UNLK1 8'h25
`define BPC_D_UNLK2 8'h03
`define BPC_D_UNLK_END 8'h29
`define BPC_D_CLR1 8'h80
`define BPC_D_CLR2 8'h30
`define BPC_PORT_X8 4'h8
`define BPC_PORT_X16 4'h4
`define BPC_UNLK_PRE 4'h2
`define BPC_CLK_NS 10
`define BPC_GAP_NS 6000
`define BPC_GAP_CYC ((`BPC_GAP_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_SETUP_CYC 2
`define BPC_PULSE_CYC 8
`define BPC_HOLD_CYC 2
`define BPC_R_CTRL 12'h000
`define BPC_R_CMD 12'h004
`define BPC_R_ADDR 12'h008
`define BPC_R_DATA 12'h00c
`define BPC_R_PWD_LO 12'h010
`define BPC_R_PWD_HI 12'h014
`define BPC_R_STATUS 12'h018
`define BPC_R_RDATA 12'h01c
`define BPC_ST_REFUSED 1
`endif

// file: logic/bpc_pkg.sv
// types of the block protection command controller
`include "bpc_consts.svh"
package bpc_pkg;
  typedef enum logic [3:0] {OP_READ, OP_ENTER, OP_EXIT, OP_PROG, OP_CLEAR, OP_UNLOCK} bpc_op_e;
  typedef enum logic [1:0] {F_IDLE, F_ISSUE, F_WAIT} bpc_fsm_e;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} bpc_cph_e;
  typedef struct packed {
    logic wr;
    logic last;
    logic [`BPC_AW-1:0] addr;
    logic [15:0] data;
  } bpc_cyc_s;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [`BPC_AW-1:0] addr;
    logic [15:0] dq;
  } bpc_pins_s;
  localparam bpc_pins_s BPC_PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, addr: '0, dq: '0};
endpackage

// file: logic/bpc_cycle.sv
// one asynchronous flash bus cycle, write or read
`timescale 1ns/1ns
`include "bpc_consts.svh"
module bpc_cycle import bpc_pkg::*; #(
  parameter int unsigned SETUP_CYC = `BPC_SETUP_CYC,
  parameter int unsigned PULSE_CYC = `BPC_PULSE_CYC,
  parameter int unsigned HOLD_CYC = `BPC_HOLD_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire bpc_cyc_s req_in,
  input wire logic [15:0] flash_dq_in,
  output logic done_out,
  output logic [15:0] rdata_out,
  output bpc_pins_s pins_out
);
  typedef struct packed {
    bpc_cph_e ph;
    logic [7:0] cnt;
    logic wr;
    logic done;
    logic [15:0] rdata;
    logic [15:0] sy1;
    logic [15:0] sy2;
    bpc_pins_s pins;
  } bpc_cst_s;
  localparam bpc_cst_s CST_RST = '{ph: C_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0, rdata: 16'h0000,
                                   sy1: 16'h0000, sy2: 16'h0000, pins: BPC_PINS_IDLE};
  bpc_cst_s s_reg;
  bpc_cst_s s_next;

  // read data crosses from the pins through sy1/sy2; the strobe must outlast that latency
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.sy1 = flash_dq_in;
    s_next.sy2 = s_reg.sy1;
    case (s_reg.ph)
      C_IDLE: begin
        if (req_valid_in) begin
          s_next.ph = C_SETUP;
          s_next.cnt = 8'(SETUP_CYC - 1);
          s_next.wr = req_in.wr;
          s_next.pins.ce_n = 1'b0;
          s_next.pins.addr = req_in.addr;
          s_next.pins.dq = req_in.data;
          s_next.pins.dq_oe = req_in.wr;
        end
      end
      C_SETUP: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.ph = C_PULSE;
          s_next.cnt = 8'(PULSE_CYC - 1);
          s_next.pins.we_n = ~s_reg.wr;
          s_next.pins.oe_n = s_reg.wr;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      C_PULSE: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.ph = C_HOLD;
          s_next.cnt = 8'(HOLD_CYC - 1);
          s_next.pins.we_n = 1'b1;
          s_next.pins.oe_n = 1'b1;
          if (!s_reg.wr) begin
            s_next.rdata = s_reg.sy2;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      C_HOLD: begin
        if (s_reg.cnt == 8'h00) begin
          s_next.ph = C_IDLE;
          s_next.pins.ce_n = 1'b1;
          s_next.pins.dq_oe = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      default: begin
        s_next = CST_RST;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= CST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_out = s_reg.done;
  assign rdata_out = s_reg.rdata;
  assign pins_out = s_reg.pins;
endmodule

// file: logic/bpc_ctrl.sv
// host controller issuing block protection command sequences to a parallel flash
`timescale 1ns/1ns
`include "bpc_consts.svh"
module bpc_ctrl import bpc_pkg::*; #(
  parameter logic [15:0] GAP_CYC = 16'(`BPC_GAP_CYC)
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [15:0] flash_dq_in,
  output bpc_pins_s flash_pins_out,
  output logic flash_byte_n_out
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rsync_reg;
  logic rst_n;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsync_reg <= 2'h0;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bpc_fsm_e fsm;
    logic byte_mode;
    bpc_op_e op;
    logic [`BPC_AW-1:0] addr;
    logic [15:0] data;
    logic [63:0] pwd;
    logic [3:0] step;
    logic [7:0] set_code;
    logic set_active;
    logic refused;
    logic [15:0] rdata;
    logic [15:0] gap;
    logic start;
    bpc_cyc_s cyc;
    logic [31:0] prdata;
    logic slverr;
  } bpc_st_s;
  bpc_st_s s_reg;
  bpc_st_s s_next;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic apb_setup;
  logic cmd_wr;
  logic cmd_ok;
  bpc_op_e cmd_op;
  bpc_cyc_s step_cyc;

  // ----------------------------------------
  // sequence table
  // ----------------------------------------
  function automatic bpc_cyc_s step_f(input bpc_st_s s);
    logic [`BPC_AW-1:0] a1;
    logic [`BPC_AW-1:0] a2;
    logic [3:0] nport;
    logic [3:0] idx;
    bpc_cyc_s c;
    a1 = s.byte_mode ? `BPC_A_AAA : `BPC_A_555;
    a2 = s.byte_mode ? `BPC_A_555 : `BPC_A_2AA;
    nport = s.byte_mode ? `BPC_PORT_X8 : `BPC_PORT_X16;
    idx = s.step - `BPC_UNLK_PRE;
    c.wr = 1'b1;
    c.last = 1'b0;
    c.addr = `BPC_A_ZERO;
    c.data = 16'h0000;
    case (s.op)
      OP_ENTER: begin
        case (s.step)
          4'h0: begin
            c.addr = a1;
            c.data = {8'h00, `BPC_D_UNL1};
          end
          4'h1: begin
            c.addr = a2;
            c.data = {8'h00, `BPC_D_UNL2};
          end
          default: begin
            c.addr = a1;
            c.data = {8'h00, s.data[7:0]};
            c.last = 1'b1;
          end
        endcase
      end
      OP_EXIT: begin
        // the extended memory set leaves through its own four-cycle exit
        if (s.set_code == `BPC_SET_EXTMEM) begin
          case (s.step)
            4'h0: begin
              c.addr = a1;
              c.data = {8'h00, `BPC_D_UNL1};
            end
            4'h1: begin
              c.addr = a2;
              c.data = {8'h00, `BPC_D_UNL2};
            end
            4'h2: begin
              c.addr = `BPC_A_555;
              c.data = {8'h00, `BPC_D_EXIT1};
            end
            default: begin
              c.data = {8'h00, `BPC_D_EXIT2};
              c.last = 1'b1;
            end
          endcase
        end else begin
          c.data = {8'h00, (s.step == 4'h0) ? `BPC_D_EXIT1 : `BPC_D_EXIT2};
          c.last = (s.step != 4'h0);
        end
      end
      OP_PROG: begin
        if (s.set_code == `BPC_SET_EXTMEM) begin
          c.addr = (s.step == 4'h1) ? a2 : a1;
          c.data = {8'h00, (s.step == 4'h0) ? `BPC_D_UNL1 : (s.step == 4'h1) ? `BPC_D_UNL2 : `BPC_D_PROG};
          if (s.step == 4'h3) begin
            c.addr = s.addr;
            c.data = s.data;
            c.last = 1'b1;
          end
        end else if (s.step == 4'h0) begin
          c.data = {8'h00, `BPC_D_PROG};
        end else begin
          c.addr = s.addr;
          c.data = s.data;
          c.last = 1'b1;
        end
      end
      OP_CLEAR: begin
        c.data = {8'h00, (s.step == 4'h0) ? `BPC_D_CLR1 : `BPC_D_CLR2};
        c.last = (s.step != 4'h0);
      end
      OP_UNLOCK: begin
        if (s.step == 4'h0) begin
          c.data = {8'h00, `BPC_D_UNLK1};
        end else if (s.step == 4'h1) begin
          c.data = {8'h00, `BPC_D_UNLK2};
        end else if (idx < nport) begin
          c.addr = `BPC_AW'(idx);
          c.data = s.byte_mode ? {8'h00, s.pwd[{idx[2:0], 3'h0} +: 8]} : s.pwd[{idx[1:0], 4'h0} +: 16];
        end else begin
          c.data = {8'h00, `BPC_D_UNLK_END};
          c.last = 1'b1;
        end
      end
      default: begin
        c.wr = 1'b0;
        c.addr = s.addr;
        c.last = 1'b1;
      end
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // command check and sequencing
  // ----------------------------------------
  assign apb_setup = psel_in & ~penable_in;
  assign cmd_wr = psel_in & penable_in & pwrite_in & (paddr_in == `BPC_R_CMD) & ~s_reg.slverr;
  assign cmd_op = bpc_op_e'(pwdata_in[3:0]);
  assign step_cyc = step_f(s_reg);

  always_comb begin
    case (cmd_op)
      OP_READ: cmd_ok = 1'b1;
      OP_ENTER: cmd_ok = ~s_reg.set_active & (s_reg.data[7:0] inside {`BPC_SET_LOCKREG, `BPC_SET_PWD,
                         `BPC_SET_NVB, `BPC_SET_LOCKBIT, `BPC_SET_VOLB, `BPC_SET_EXTMEM});
      OP_EXIT, OP_PROG: cmd_ok = s_reg.set_active;
      OP_CLEAR: cmd_ok = s_reg.set_active & (s_reg.set_code == `BPC_SET_NVB);
      OP_UNLOCK: cmd_ok = s_reg.set_active & (s_reg.set_code == `BPC_SET_PWD) & (s_reg.gap == 16'h0000);
      default: cmd_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    if (s_reg.gap != 16'h0000) begin
      s_next.gap = s_reg.gap - 16'h0001;
    end
    if (apb_setup) begin
      s_next.slverr = 1'b0;
      case (paddr_in)
        `BPC_R_CTRL: s_next.prdata = {31'h0, s_reg.byte_mode};
        `BPC_R_CMD: s_next.prdata = {28'h0, s_reg.op};
        `BPC_R_ADDR: s_next.prdata = {8'h00, s_reg.addr};
        `BPC_R_DATA: s_next.prdata = {16'h0000, s_reg.data};
        `BPC_R_PWD_LO: s_next.prdata = s_reg.pwd[31:0];
        `BPC_R_PWD_HI: s_next.prdata = s_reg.pwd[63:32];
        `BPC_R_STATUS: s_next.prdata = {16'h0000, s_reg.set_code, 5'h00, s_reg.set_active, s_reg.refused,
                                        s_reg.fsm != F_IDLE};
        `BPC_R_RDATA: s_next.prdata = {16'h0000, s_reg.rdata};
        default: begin
          s_next.prdata = 32'h0000_0000;
          s_next.slverr = 1'b1;
        end
      endcase
    end
    // operands stay frozen while a sequence runs
    if (psel_in & penable_in & pwrite_in & ~s_reg.slverr) begin
      case (paddr_in)
        `BPC_R_CTRL: if (s_reg.fsm == F_IDLE) s_next.byte_mode = pwdata_in[0];
        `BPC_R_ADDR: if (s_reg.fsm == F_IDLE) s_next.addr = pwdata_in[`BPC_AW-1:0];
        `BPC_R_DATA: if (s_reg.fsm == F_IDLE) s_next.data = pwdata_in[15:0];
        `BPC_R_PWD_LO: if (s_reg.fsm == F_IDLE) s_next.pwd[31:0] = pwdata_in;
        `BPC_R_PWD_HI: if (s_reg.fsm == F_IDLE) s_next.pwd[63:32] = pwdata_in;
        `BPC_R_STATUS: if (pwdata_in[`BPC_ST_REFUSED]) s_next.refused = 1'b0;
        default: begin
        end
      endcase
    end
    case (s_reg.fsm)
      F_IDLE: begin
        if (cmd_wr) begin
          if (cmd_ok) begin
            s_next.op = cmd_op;
            s_next.step = 4'h0;
            s_next.fsm = F_ISSUE;
          end else begin
            s_next.refused = 1'b1;
          end
        end
      end
      F_ISSUE: begin
        s_next.cyc = step_cyc;
        s_next.start = 1'b1;
        s_next.fsm = F_WAIT;
      end
      F_WAIT: begin
        if (cmd_wr) begin
          s_next.refused = 1'b1;
        end
        if (cyc_done) begin
          if (!s_reg.cyc.wr) begin
            s_next.rdata = cyc_rdata;
          end
          if (s_reg.cyc.last) begin
            s_next.fsm = F_IDLE;
            case (s_reg.op)
              OP_ENTER: begin
                s_next.set_active = 1'b1;
                s_next.set_code = s_reg.data[7:0];
              end
              OP_EXIT: begin
                s_next.set_active = 1'b0;
                s_next.set_code = 8'h00;
              end
              OP_UNLOCK: s_next.gap = GAP_CYC;
              default: begin
              end
            endcase
          end else begin
            s_next.step = s_reg.step + 4'h1;
            s_next.fsm = F_ISSUE;
          end
        end
      end
      default: begin
        s_next.fsm = F_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // bus cycle engine and outputs
  // ----------------------------------------
  bpc_cycle bpc_cycle_inst (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .req_valid_in(s_reg.start),
    .req_in(s_reg.cyc),
    .flash_dq_in(flash_dq_in),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .pins_out(flash_pins_out)
  );

  assign prdata_out = s_reg.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & s_reg.slverr;
  assign flash_byte_n_out = ~s_reg.byte_mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  sequence s_cs(bpc_op_e o, logic [3:0] st);
    s_reg.start && s_reg.op == o && s_reg.step == st;
  endsequence
  sequence s_plain_exit;
    s_cs(OP_EXIT, 4'h0) ##0 s_reg.set_code != `BPC_SET_EXTMEM;
  endsequence

  AST_ENTER_X8: assert property (s_cs(OP_ENTER, 4'h2) ##0 s_reg.byte_mode |->
    s_reg.cyc.addr == `BPC_A_AAA && s_reg.cyc.data[7:0] == s_reg.data[7:0] && s_reg.cyc.last)
    else $error("byte-mode entry third cycle wrong");
  AST_ENTER_X16: assert property (s_cs(OP_ENTER, 4'h1) ##0 !s_reg.byte_mode |->
    s_reg.cyc.addr == `BPC_A_2AA && s_reg.cyc.data[7:0] == `BPC_D_UNL2)
    else $error("word-mode entry second cycle wrong");
  AST_EXIT: assert property (s_plain_exit |-> s_reg.cyc.data[7:0] == `BPC_D_EXIT1 ##[1:300]
    (s_reg.start && s_reg.cyc.last && s_reg.cyc.data[7:0] == `BPC_D_EXIT2))
    else $error("exit sequence wrong");
  AST_NOSET: assert property (cmd_wr && s_reg.fsm == F_IDLE && (cmd_op == OP_PROG || cmd_op == OP_EXIT) &&
    !s_reg.set_active |=>
    s_reg.refused && s_reg.fsm == F_IDLE)
    else $error("program without entered set not refused");
  AST_PROG: assert property (s_cs(OP_PROG, 4'h0) ##0 s_reg.set_code != `BPC_SET_EXTMEM |->
    s_reg.cyc.data[7:0] == `BPC_D_PROG && s_reg.cyc.wr && !s_reg.cyc.last)
    else $error("program command cycle wrong");
  AST_UNLK_PORT: assert property (s_cs(OP_UNLOCK, 4'h2) |-> s_reg.cyc.addr == `BPC_A_ZERO &&
    s_reg.cyc.data[7:0] == s_reg.pwd[7:0])
    else $error("first password portion wrong");
  AST_UNLK_LEN: assert property (s_reg.start && s_reg.op == OP_UNLOCK && s_reg.cyc.last |->
    s_reg.step == (s_reg.byte_mode ? 4'ha : 4'h6) && s_reg.cyc.data[7:0] == `BPC_D_UNLK_END)
    else $error("unlock length wrong");
  AST_UNLK_GAP: assert property (cmd_wr && s_reg.fsm == F_IDLE && cmd_op == OP_UNLOCK && s_reg.gap != 16'h0000 |=>
    s_reg.refused && s_reg.fsm == F_IDLE)
    else $error("unlock too soon not refused");
  AST_CLEAR: assert property (s_reg.start && s_reg.op == OP_CLEAR && s_reg.cyc.last |->
    s_reg.cyc.addr == `BPC_A_ZERO && s_reg.cyc.data[7:0] == `BPC_D_CLR2 && $past(s_reg.fsm) == F_ISSUE)
    else $error("clear-all second cycle wrong");
endmodule

// file: sim/bpc_flash_model.sv
// behavioural model of the flash protection command sets
`timescale 1ns/1ns
`include "bpc_consts.svh"
module bpc_flash_model import bpc_pkg::*; #(
  parameter int GAP_NS = 200,
  parameter int PWD_MODE_BIT = 2
) (
  input wire bpc_pins_s pins_in,
  input wire logic byte_n_in,
  output logic [15:0] dq_out
);
  logic [7:0] mode, st, cnt, d;
  logic [15:0] lockreg, rval, held, a;
  logic [63:0] pwd, try_pwd;
  logic [255:0] nvb, vol;
  logic lock_bit, rd;
  int n_wr, n_unlock;
  time last_unlock, t_start;
  initial begin
    mode = 8'h00; st = 8'h00; cnt = 8'h00; lockreg = 16'hffff; pwd = '1; try_pwd = '1;
    nvb = '1; vol = '1; lock_bit = 1'b1; n_wr = 0; n_unlock = 0; last_unlock = 0; t_start = 0;
    held = 16'h0000;
  end
  task automatic put(inout logic [63:0] p);
    if (byte_n_in) p[16*a[1:0] +: 16] = pins_in.dq;
    else p[8*a[2:0] +: 8] = d;
  endtask
  // ----------------------------------------
  // write cycles, taken at the rising write strobe
  // ----------------------------------------
  always @(posedge pins_in.we_n) begin
    if (pins_in.ce_n === 1'b0) begin
      n_wr = n_wr + 1;
      d = pins_in.dq[7:0];
      a = pins_in.addr[15:0];
      if (mode == 8'h00) begin
        if (st == 0 && d == 8'haa && a == (byte_n_in ? 16'h555 : 16'haaa)) st = 1;
        else if (st == 1 && d == 8'h55 && a == (byte_n_in ? 16'h2aa : 16'h555)) st = 2;
        else if (st == 2 && a == (byte_n_in ? 16'h555 : 16'haaa) &&
                 d inside {8'h40, 8'h60, 8'hc0, 8'h50, 8'he0, 8'h88}) begin
          mode = d;
          st = 0;
        end else st = 0;
      end else if (mode == 8'h88 && st < 2) begin
        st = ((st == 0 && d == 8'haa) || (st == 1 && d == 8'h55)) ? st + 1 : 0;
      end else begin
        case (st)
          0, 2: begin
            st = (d == 8'h90) ? 10 : (d == 8'ha0) ? 20 : (d == 8'h80) ? 30 : 0;
            if (d == 8'h25 && a == 0 && mode == 8'h60) st = 40;
            t_start = $time;
          end
          10: begin
            if (d == 8'h00) mode = 8'h00;
            st = 0;
          end
          20: begin
            case (mode)
              8'h40: lockreg = pins_in.dq;
              8'h60: put(pwd);
              8'hc0: if (d == 8'h00 && lock_bit) nvb[pins_in.addr[23:16]] = 1'b0;
              8'h50: if (d == 8'h00) lock_bit = 1'b0;
              8'he0: if (d inside {8'h00, 8'h01}) vol[pins_in.addr[23:16]] = d[0];
              default: ;
            endcase
            st = 0;
          end
          30: begin
            // program-then-erase collapses to one step in this model
            if (d == 8'h30 && a == 0 && mode == 8'hc0 && lock_bit) nvb = '1;
            st = 0;
          end
          40: begin
            st = (d == 8'h03 && a == 0) ? 41 : 0;
            cnt = 0;
          end
          41: begin
            if (cnt < (byte_n_in ? 4 : 8)) begin
              put(try_pwd);
              cnt = cnt + 1;
            end else begin
              if (d == 8'h29 && a == 0 && t_start - last_unlock >= GAP_NS) begin
                n_unlock = n_unlock + 1;
                if (try_pwd == pwd) lock_bit = 1'b1;
              end
              last_unlock = $time;
              st = 0;
            end
          end
          default: st = 0;
        endcase
      end
    end
  end
  // ----------------------------------------
  // read cycles; a released bus shows the inverse of its last value
  // ----------------------------------------
  assign rd = (pins_in.ce_n === 1'b0) && (pins_in.oe_n === 1'b0);
  always @* begin
    case (mode)
      8'h40: rval = lockreg;
      8'h60: rval = byte_n_in ? pwd[16*pins_in.addr[1:0] +: 16] : {8'h00, pwd[8*pins_in.addr[2:0] +: 8]};
      8'hc0: rval = {15'h0000, nvb[pins_in.addr[23:16]]};
      8'h50: rval = {15'h0000, lock_bit};
      8'he0: rval = {15'h0000, vol[pins_in.addr[23:16]]};
      default: rval = pins_in.addr[15:0] ^ 16'h3c3c;
    endcase
    // once password mode is locked the stored password never leaves the part
    if (mode == 8'h60 && !lockreg[PWD_MODE_BIT]) rval = 16'h0000;
  end
  always @* if (rd) held = rval;
  assign dq_out = pins_in.dq_oe ? pins_in.dq : (rd ? rval : ~held);
endmodule

// file: sim/bpc_ctrl_tb.sv
// self-checking testbench of the block protection command controller
`timescale 1ns/1ns
`include "bpc_consts.svh"
module bpc_ctrl_tb import bpc_pkg::*; ;
  localparam logic [7:0] SETS [6] = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0, 8'h88};
  localparam logic [63:0] PWD = 64'h8e31d2a75bc4f609;
  logic clock_in, rst_n_in, psel, penable, pwrite, pready, pslverr, byte_n, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] dq;
  bpc_pins_s pins;
  int n_fail, tests_run, cycles, w0;
  bpc_ctrl #(.GAP_CYC(16'd20)) bpc_ctrl_inst (.clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .flash_dq_in(dq), .flash_pins_out(pins), .flash_byte_n_out(byte_n));
  bpc_flash_model #(.GAP_NS(200)) bpc_flash_model_inst (.pins_in(pins), .byte_n_in(byte_n), .dq_out(dq));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic op(input bpc_op_e code, input logic [23:0] a, input logic [15:0] d);
    int k;
    apb(1'b1, `BPC_R_ADDR, 32'(a));
    apb(1'b1, `BPC_R_DATA, 32'(d));
    apb(1'b1, `BPC_R_CMD, 32'(code));
    k = 0;
    do begin
      apb(1'b0, `BPC_R_STATUS, 32'h0);
      k++;
    end while (rv[0] !== 1'b0 && k < 300);
    chk(32'(rv[0]), 32'h0);
  endtask
  task automatic refused(input logic exp);
    apb(1'b0, `BPC_R_STATUS, 32'h0);
    chk(32'(rv[1]), 32'(exp));
    apb(1'b1, `BPC_R_STATUS, 32'h2);
  endtask
  task automatic rd_chk(input logic [23:0] a, input logic [31:0] exp);
    op(OP_READ, a, 16'h0);
    apb(1'b0, `BPC_R_RDATA, 32'h0);
    chk(rv, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(32'({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, byte_n}), 32'h1d);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(rv, 32'h0);
    op(OP_EXIT, 24'h0, 16'h0);
    refused(1'b1);
    chk(32'(bpc_flash_model_inst.n_wr), 32'h0);
    rd_chk(24'h0, 32'h3c3c);
    $display("test reset done");
  endtask
  task automatic t_enter_all();
    foreach (SETS[i]) begin
      w0 = bpc_flash_model_inst.n_wr;
      op(OP_ENTER, 24'h0, 16'(SETS[i]));
      chk(32'(bpc_flash_model_inst.n_wr - w0), 32'h3);
      chk(32'(bpc_flash_model_inst.mode), 32'(SETS[i]));
      apb(1'b0, `BPC_R_STATUS, 32'h0);
      chk(32'(rv[15:8]), 32'(SETS[i]));
      op(OP_EXIT, 24'h0, 16'h0);
      chk(32'(bpc_flash_model_inst.mode), 32'h0);
    end
    op(OP_ENTER, 24'h0, 16'h77);
    refused(1'b1);
    $display("test enter all done");
  endtask
  task automatic t_volatile();
    op(OP_ENTER, 24'h0, 16'he0);
    op(OP_PROG, 24'h050000, 16'h0000);
    chk(32'(bpc_flash_model_inst.vol[5]), 32'h0);
    rd_chk(24'h050000, 32'h0);
    op(OP_PROG, 24'h050000, 16'h0001);
    chk(32'(bpc_flash_model_inst.vol[5]), 32'h1);
    op(OP_EXIT, 24'h0, 16'h0);
    $display("test volatile done");
  endtask
  task automatic t_byte_nvb();
    apb(1'b1, `BPC_R_CTRL, 32'h1);
    chk(32'(byte_n), 32'h0);
    op(OP_ENTER, 24'h0, 16'hc0);
    chk(32'(bpc_flash_model_inst.mode), 32'hc0);
    op(OP_PROG, 24'h030000, 16'h0000);
    chk(32'(bpc_flash_model_inst.nvb[3]), 32'h0);
    rd_chk(24'h030000, 32'h0);
    rd_chk(24'h040000, 32'h1);
    op(OP_ENTER, 24'h0, 16'h40);
    refused(1'b1);
    op(OP_CLEAR, 24'h0, 16'h0);
    chk(32'(bpc_flash_model_inst.nvb[3]), 32'h1);
    op(OP_EXIT, 24'h0, 16'h0);
    $display("test byte nonvolatile done");
  endtask
  task automatic t_lock();
    apb(1'b1, `BPC_R_CTRL, 32'h0);
    op(OP_ENTER, 24'h0, 16'h40);
    op(OP_PROG, 24'h0, 16'h1234);
    rd_chk(24'h0, 32'h1234);
    op(OP_EXIT, 24'h0, 16'h0);
    op(OP_ENTER, 24'h0, 16'h50);
    op(OP_PROG, 24'h0, 16'h0000);
    rd_chk(24'h0, 32'h0);
    op(OP_EXIT, 24'h0, 16'h0);
    $display("test lock done");
  endtask
  task automatic t_password();
    apb(1'b1, `BPC_R_CTRL, 32'h1);
    op(OP_ENTER, 24'h0, 16'h60);
    for (int i = 7; i >= 0; i--) op(OP_PROG, 24'(i), 16'(PWD[8*i +: 8]));
    chk(bpc_flash_model_inst.pwd[31:0], PWD[31:0]);
    chk(bpc_flash_model_inst.pwd[63:32], PWD[63:32]);
    for (int i = 0; i < 8; i++) rd_chk(24'(i), 32'(PWD[8*i +: 8]));
    apb(1'b1, `BPC_R_PWD_LO, PWD[31:0]);
    apb(1'b1, `BPC_R_PWD_HI, PWD[63:32]);
    w0 = bpc_flash_model_inst.n_wr;
    op(OP_UNLOCK, 24'h0, 16'h0);
    chk(32'(bpc_flash_model_inst.n_wr - w0), 32'd11);
    chk(32'(bpc_flash_model_inst.lock_bit), 32'h1);
    op(OP_UNLOCK, 24'h0, 16'h0);
    refused(1'b1);
    repeat (25) @(posedge clock_in);
    op(OP_UNLOCK, 24'h0, 16'h0);
    chk(32'(bpc_flash_model_inst.n_unlock), 32'd2);
    apb(1'b1, `BPC_R_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) rd_chk(24'(i), 32'(PWD[16*i +: 16]));
    repeat (25) @(posedge clock_in);
    w0 = bpc_flash_model_inst.n_wr;
    op(OP_UNLOCK, 24'h0, 16'h0);
    chk(32'(bpc_flash_model_inst.n_wr - w0), 32'd7);
    chk(32'(bpc_flash_model_inst.n_unlock), 32'd3);
    op(OP_EXIT, 24'h0, 16'h0);
    op(OP_ENTER, 24'h0, 16'h40);
    op(OP_PROG, 24'h0, 16'hfffb);
    op(OP_EXIT, 24'h0, 16'h0);
    op(OP_ENTER, 24'h0, 16'h60);
    rd_chk(24'h1, 32'h0);
    op(OP_EXIT, 24'h0, 16'h0);
    $display("test password done");
  endtask
  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    n_fail = 0; tests_run = 0; cycles = 0; rst_n_in = 1'b0; rv = 32'h0; e = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    t_reset();
    t_enter_all();
    t_volatile();
    t_byte_nvb();
    t_lock();
    t_password();
    complete_run();
  end
endmodule
